// [supply_monitor_regs.vh]
`ifndef SUPPLY_MONITOR_REGS_VH
`define SUPPLY_MONITOR_REGS_VH

// byte addresses on the register bus
`define SM_ADDR_CTRL_STATUS 16'h3040
`define SM_ADDR_IRQ_STATUS 16'h3044
`define SM_ADDR_IRQ_ENABLE 16'h3048
`define SM_ADDR_IRQ_CLEAR 16'h304c
`define SM_ADDR_LSB 2

// control/status field positions
`define SM_BIT_WARN_FLAG 7
`define SM_BIT_WARN_ACK 6
`define SM_BIT_WARN_IE 5
`define SM_BIT_DET_RE 4
`define SM_BIT_DET_SE 3
`define SM_BIT_DET_EN 2
`define SM_BIT_BUF_DS 1
`define SM_BIT_BUF_EN 0

// reset values of the control bits (reads 1ch after reset)
`define SM_RST_WARN_IE 1'b0
`define SM_RST_DET_RE 1'b1
`define SM_RST_DET_SE 1'b1
`define SM_RST_DET_EN 1'b1
`define SM_RST_BUF_DS 1'b0
`define SM_RST_BUF_EN 1'b0

// interrupt event bit positions
`define SM_EV_WARN_RISE 0
`define SM_EV_DETECT 1
`define SM_EV_COUNT 2

// synchroniser and write-once slots
`define SM_CMP_WARN 0
`define SM_CMP_DET 1
`define SM_CMP_COUNT 2
`define SM_ONCE_RE 0
`define SM_ONCE_DE 1
`define SM_ONCE_COUNT 2

// axi response codes
`define SM_RESP_OKAY 2'b00
`define SM_RESP_SLVERR 2'b10

`endif

// [low_voltage_monitor_ctrl.v]
`timescale 1ns/1ps
`include "supply_monitor_regs.vh"
// Operation
// R1: control/status register sits at absolute address 3040h.
// R2: warning flag bit 7 sets on supply warning, also when present after reset.
// R3: warning flag stays 1 until software clears it; 0 means no warning.
// R4: writing 1 to ack bit 6 clears flag only if warning gone.
// R5: interrupt requested while flag and enable bit 5 are both 1.
// R6: reset-enable bit 4 with detection on forces reset on detect events.
// R7: reset-enable bit accepts only the first write after each reset.
// R8: stop-enable bit 3 keeps detection running in stop mode; freely writable.
// R9: detect-enable bit 2 gates detection; reset and stop enables need it.
// R10: detect-enable bit accepts only the first write after each reset.
// R11: software should write the register once during reset initialization.
// R12: software clears the flag by acknowledge before enabling the interrupt.
// R13: bit 0 enables the reference buffer for the converter channel.
// R14: bit 1 selects high buffer drive, meaningful only while buffer enabled.
// R15: comparator outputs pass synchronizer flip-flops before use.
// R16: acknowledge bit reads 0, holds no state; writing 0 does nothing.
module low_voltage_monitor_ctrl (
    input wire core_clk,
    input wire nrst,
    input wire supply_warning,
    input wire supply_detect,
    input wire stop_mode,
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg warning_irq,
    output reg system_reset_req,
    output reg detect_active,
    output reg ref_buffer_enable_out,
    output reg ref_buffer_drive_select_out,
    output reg irq
);

    // release is synchronous so every flop leaves reset on the same edge
    reg rst_meta;
    reg rst_sync_n;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // three stages per comparator; a change counts once stage two and three agree
    wire [`SM_CMP_COUNT-1:0] cmp_raw;
    wire [`SM_CMP_COUNT-1:0] cmp_level;
    assign cmp_raw[`SM_CMP_WARN] = supply_warning;
    assign cmp_raw[`SM_CMP_DET] = supply_detect;

    genvar si;
    generate
        for (si = 0; si < `SM_CMP_COUNT; si = si + 1) begin : g_sync
            reg [2:0] stages;
            reg level;
            always @(posedge core_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    stages <= 3'h0;
                    level <= 1'b0;
                end else begin
                    stages <= {stages[1:0], cmp_raw[si]}; // [R15]
                    // a lone disagreeing sample is a transition still settling
                    if (stages[1] == stages[2]) begin
                        level <= stages[2]; // [R15]
                    end
                end
            end
            assign cmp_level[si] = level;
        end
    endgenerate

    wire warn_level = cmp_level[`SM_CMP_WARN];
    wire det_level = cmp_level[`SM_CMP_DET];

    reg warning_flag;
    reg warning_irq_enable;
    wire detect_reset_enable;
    reg detect_stop_enable;
    wire detect_enable;
    reg ref_buffer_enable;
    reg ref_buffer_drive_select;
    reg det_level_d;
    reg [`SM_EV_COUNT-1:0] irq_status;
    reg [`SM_EV_COUNT-1:0] irq_enable;

    // write channel: address and data held until both are present
    reg aw_held;
    reg w_held;
    reg [15:0] wr_addr;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire [15:0] wr_word = {wr_addr[15:`SM_ADDR_LSB], 2'b00};
    // only byte lane 0 carries register bits; the other lanes are ignored
    wire wr_ctrl = do_write && (wr_word == `SM_ADDR_CTRL_STATUS) && wr_strb[0]; // [R1]
    wire wr_ien = do_write && (wr_word == `SM_ADDR_IRQ_ENABLE) && wr_strb[0];
    wire wr_iclr = do_write && (wr_word == `SM_ADDR_IRQ_CLEAR) && wr_strb[0];
    reg wr_hit;

    always @* begin
        wr_hit = 1'b1;
        case (wr_word)
            `SM_ADDR_CTRL_STATUS: wr_hit = 1'b1; // [R1]
            `SM_ADDR_IRQ_STATUS: wr_hit = 1'b1;
            `SM_ADDR_IRQ_ENABLE: wr_hit = 1'b1;
            `SM_ADDR_IRQ_CLEAR: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // address and data close on their own take and reopen only once the
    // response is accepted, so at most one write is under way
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_awready <= 1'b1;
            aw_held <= 1'b0;
            wr_addr <= 16'h0000;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_wready <= 1'b1;
            w_held <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (w_take) begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                w_held <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SM_RESP_OKAY;
        end else begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `SM_RESP_OKAY : `SM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire det_on = detect_enable && (!stop_mode || detect_stop_enable); // [R8] [R9]
    // a detect level already high when detection turns on raises no event
    wire det_event = det_on && det_level && !det_level_d;
    wire warn_rise = warn_level && !warning_flag;
    // ack is only a strobe: nothing stores it, so its bit reads zero
    wire ack = wr_ctrl && wr_data[`SM_BIT_WARN_ACK] && !warn_level; // [R4] [R16]

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            warning_flag <= 1'b0;
            det_level_d <= 1'b0;
        end else begin
            det_level_d <= det_level;
            // a present warning, even one already there after reset, wins over ack
            if (warn_level) begin
                warning_flag <= 1'b1; // [R2] [R3]
            end else if (ack) begin
                warning_flag <= 1'b0; // [R4]
            end
        end
    end

    // freely writable control bits
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            warning_irq_enable <= `SM_RST_WARN_IE;
            detect_stop_enable <= `SM_RST_DET_SE;
            ref_buffer_enable <= `SM_RST_BUF_EN;
            ref_buffer_drive_select <= `SM_RST_BUF_DS;
        end else if (wr_ctrl) begin
            warning_irq_enable <= wr_data[`SM_BIT_WARN_IE]; // [R5]
            detect_stop_enable <= wr_data[`SM_BIT_DET_SE]; // [R8]
            ref_buffer_enable <= wr_data[`SM_BIT_BUF_EN]; // [R13]
            ref_buffer_drive_select <= wr_data[`SM_BIT_BUF_DS]; // [R14]
        end
    end

    // write-once bits: any control write locks both, so a boot routine
    // that rewrites the reset values still fixes them on purpose
    wire [`SM_ONCE_COUNT-1:0] once_wdata;
    wire [`SM_ONCE_COUNT-1:0] once_value;
    assign once_wdata[`SM_ONCE_RE] = wr_data[`SM_BIT_DET_RE];
    assign once_wdata[`SM_ONCE_DE] = wr_data[`SM_BIT_DET_EN];

    genvar oi;
    generate
        for (oi = 0; oi < `SM_ONCE_COUNT; oi = oi + 1) begin : g_once
            reg value;
            reg locked;
            always @(posedge core_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    value <= (oi == `SM_ONCE_DE) ? `SM_RST_DET_EN : `SM_RST_DET_RE;
                    locked <= 1'b0;
                end else if (wr_ctrl) begin
                    locked <= 1'b1; // [R7] [R10]
                    if (!locked) begin
                        value <= once_wdata[oi]; // [R7] [R10]
                    end
                end
            end
            assign once_value[oi] = value;
        end
    endgenerate

    assign detect_reset_enable = once_value[`SM_ONCE_RE];
    assign detect_enable = once_value[`SM_ONCE_DE];

    // event status: set beats a simultaneous clear
    wire [`SM_EV_COUNT-1:0] ev_set;
    assign ev_set[`SM_EV_WARN_RISE] = warn_rise;
    assign ev_set[`SM_EV_DETECT] = det_event;

    genvar gi;
    generate
        for (gi = 0; gi < `SM_EV_COUNT; gi = gi + 1) begin : g_ev
            always @(posedge core_clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    irq_status[gi] <= 1'b0;
                    irq_enable[gi] <= 1'b0;
                end else begin
                    if (ev_set[gi]) begin
                        irq_status[gi] <= 1'b1;
                    end else if (wr_iclr && wr_data[gi]) begin
                        irq_status[gi] <= 1'b0;
                    end
                    if (wr_ien) begin
                        irq_enable[gi] <= wr_data[gi];
                    end
                end
            end
        end
    endgenerate

    wire [7:0] ctrl_read = {warning_flag, 1'b0, warning_irq_enable, detect_reset_enable,
        detect_stop_enable, detect_enable, ref_buffer_drive_select, ref_buffer_enable};

    wire [15:0] rd_word = {s_axi_araddr[15:`SM_ADDR_LSB], 2'b00};
    reg [31:0] next_rdata;
    reg next_rhit;

    always @* begin
        next_rdata = 32'h00000000;
        next_rhit = 1'b1;
        case (rd_word)
            `SM_ADDR_CTRL_STATUS: next_rdata = {24'h000000, ctrl_read}; // [R1] [R16]
            `SM_ADDR_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
            `SM_ADDR_IRQ_ENABLE: next_rdata = {30'h00000000, irq_enable};
            // clear register is write-only and reads back as zero
            `SM_ADDR_IRQ_CLEAR: next_rdata = 32'h00000000;
            default: next_rhit = 1'b0;
        endcase
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SM_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rhit ? `SM_RESP_OKAY : `SM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            warning_irq <= 1'b0;
            system_reset_req <= 1'b0;
            detect_active <= 1'b0;
            ref_buffer_enable_out <= 1'b0;
            ref_buffer_drive_select_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            // every pin comes from a flop so no decode glitch reaches it
            warning_irq <= warning_flag && warning_irq_enable; // [R5]
            // held while detect level stands so the reset generator sees a level
            system_reset_req <= det_on && detect_reset_enable && det_level; // [R6] [R9]
            detect_active <= det_on; // [R8] [R9]
            ref_buffer_enable_out <= ref_buffer_enable; // [R13]
            ref_buffer_drive_select_out <= ref_buffer_enable && ref_buffer_drive_select; // [R14]
            irq <= |(irq_status & irq_enable);
        end
    end

endmodule // low_voltage_monitor_ctrl

// [low_voltage_monitor_ctrl_assertions.sv]
`timescale 1ns/1ps
module low_voltage_monitor_ctrl_checker (
    input wire core_clk,
    input wire nrst,
    input wire stop_mode,
    input wire supply_detect,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire system_reset_req,
    input wire detect_active,
    input wire ref_buffer_enable_out,
    input wire ref_buffer_drive_select_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped early");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    AST_BUSY_NO_TAKE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channel ready while response pending");
    AST_RESET_QUIET: assert property (!supply_detect [*8] |=> !system_reset_req)
        else $error("reset request without detect");
    AST_DRIVE_NEEDS_BUF: assert property (ref_buffer_drive_select_out |-> ref_buffer_enable_out)
        else $error("drive select without buffer enable");
    AST_DETECT_OFF: assert property (!detect_active |-> !system_reset_req)
        else $error("reset request with detection off");
    cover property (system_reset_req);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (!detect_active && stop_mode);
endmodule // low_voltage_monitor_ctrl_checker

bind low_voltage_monitor_ctrl low_voltage_monitor_ctrl_checker chk_inst (.core_clk, .nrst, .stop_mode, .supply_detect,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .system_reset_req, .detect_active,
    .ref_buffer_enable_out, .ref_buffer_drive_select_out);

// [low_voltage_monitor_ctrl_tb_top.sv]
`timescale 1ns/1ps
`include "supply_monitor_regs.vh"
module low_voltage_monitor_ctrl_tb_top;
    reg core_clk = 0, nrst = 0, supply_warning = 0, supply_detect = 0, stop_mode = 0;
    reg [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire warning_irq, system_reset_req, detect_active, ref_buffer_enable_out, ref_buffer_drive_select_out, irq;
    integer n_mismatch = 0, comparisons = 0, cyc = 0, seed = 41, i;
    reg [7:0] m;
    reg lk;
    reg [31:0] d;
    reg [1:0] r;
    low_voltage_monitor_ctrl low_voltage_monitor_ctrl_inst (.core_clk, .nrst, .supply_warning, .supply_detect,
        .stop_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .warning_irq, .system_reset_req, .detect_active,
        .ref_buffer_enable_out, .ref_buffer_drive_select_out, .irq);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        begin
            $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
            if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    // address and data offered together, each released once taken
    task axw(input [15:0] a, input [31:0] v);
        begin
            @(posedge core_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            do begin
                @(posedge core_clk);
                if (s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wready) s_axi_wvalid <= 0;
            end while (s_axi_bvalid !== 1'b1);
            r = s_axi_bresp;
            s_axi_bready <= 0;
        end
    endtask
    task axr(input [15:0] a);
        begin
            @(posedge core_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            do begin
                @(posedge core_clk);
                if (s_axi_arready) s_axi_arvalid <= 0;
            end while (s_axi_rvalid !== 1'b1);
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 0;
        end
    endtask
    task rdc;
        begin
            axr(`SM_ADDR_CTRL_STATUS);
            chk(d, {24'h0, m});
            chk(ref_buffer_enable_out, m[0]);
            chk(ref_buffer_drive_select_out, m[1] & m[0]);
            chk(warning_irq, m[7] & m[5]);
        end
    endtask
    // model: write-once bits freeze after the first write; ack loses to a live warning
    task ctl(input [7:0] v);
        begin
            axw(`SM_ADDR_CTRL_STATUS, {24'h0, v});
            chk(r, `SM_RESP_OKAY);
            m = {m[7] & ~(v[6] & ~supply_warning), 1'b0, v[5], lk ? m[4] : v[4], v[3], lk ? m[2] : v[2], v[1:0]};
            lk = 1;
            rdc;
        end
    endtask
    initial begin
        m = 8'h1c;
        lk = 0;
        tick(20);
        nrst <= 1;
        tick(4);
        rdc;
        axr(16'h3050);
        chk(r, `SM_RESP_SLVERR);
        supply_warning <= 1;
        tick(8);
        m[7] = 1;
        rdc;
        ctl(8'h5c);
        supply_warning <= 0;
        tick(8);
        ctl(8'h5c);
        ctl(8'h3c);
        supply_warning <= 1;
        tick(8);
        m[7] = 1;
        rdc;
        supply_warning <= 0;
        tick(8);
        rdc;
        stop_mode <= 1;
        tick(3);
        chk(detect_active, 1);
        ctl(8'h27);
        chk(detect_active, 0);
        stop_mode <= 0;
        tick(3);
        chk(detect_active, 1);
        supply_detect <= 1;
        tick(8);
        chk(system_reset_req, 1);
        axw(`SM_ADDR_IRQ_ENABLE, 32'h0);
        axr(`SM_ADDR_IRQ_STATUS);
        chk(d, 32'h3);
        chk(irq, 0);
        axw(`SM_ADDR_IRQ_ENABLE, 32'h3);
        tick(2);
        chk(irq, 1);
        supply_detect <= 0;
        tick(8);
        chk(system_reset_req, 0);
        axw(`SM_ADDR_IRQ_CLEAR, 32'h3);
        axr(`SM_ADDR_IRQ_STATUS);
        chk(d, 32'h0);
        tick(2);
        chk(irq, 0);
        for (i = 0; i < 4; i = i + 1) begin
            d = $random(seed);
            ctl(d[7:0]);
        end
        nrst <= 0;
        tick(3);
        nrst <= 1;
        tick(4);
        m = 8'h1c;
        lk = 0;
        s_axi_wstrb <= 4'h0;
        axw(`SM_ADDR_CTRL_STATUS, 32'hff);
        s_axi_wstrb <= 4'hf;
        chk(r, `SM_RESP_OKAY);
        rdc;
        ctl(8'h00);
        chk(detect_active, 0);
        supply_detect <= 1;
        tick(8);
        chk(system_reset_req, 0);
        ctl(8'h1c);
        axw(16'h3050, 32'hff);
        chk(r, `SM_RESP_SLVERR);
        report_and_stop;
    end
endmodule // low_voltage_monitor_ctrl_tb_top
